// ### elmc_ctrl.sv
// Loopback, alarm-ones, channel monitor select and command register bank
`timescale 1ns/1ps
module elmc_ctrl import elmc_pkg::*; (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Parallel control port
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // Line pins
    input wire logic line_rx_pos_in_i,
    input wire logic line_rx_neg_in_i,
    input wire logic line_tx_pos_in_i,
    input wire logic line_tx_neg_in_i,
    output logic line_tx_pos_out_o,
    output logic line_tx_neg_out_o,
    // Receive path toward jitter attenuator and framer
    output logic rx_pos_to_jitter_o,
    output logic rx_neg_to_jitter_o,
    output logic framer_pos_o,
    output logic framer_neg_o,
    // Timeslot streams and snoop registers
    input wire logic [ELMC_SLOT_BITS-1:0] tx_slot_data_i,
    input wire logic [ELMC_SEL_W-1:0] tx_slot_num_i,
    input wire logic tx_slot_valid_i,
    input wire logic [ELMC_SLOT_BITS-1:0] rx_slot_data_i,
    input wire logic [ELMC_SEL_W-1:0] rx_slot_num_i,
    input wire logic rx_slot_valid_i,
    output logic [ELMC_SLOT_BITS-1:0] tx_channel_snoop_o,
    output logic [ELMC_SLOT_BITS-1:0] rx_channel_snoop_o,
    // Elastic store pointer separation and commands
    input wire logic [ELMC_PTR_W-1:0] rx_elastic_sep_i,
    input wire logic [ELMC_PTR_W-1:0] tx_elastic_sep_i,
    output logic rx_elastic_align_o,
    output logic tx_elastic_align_o,
    output logic line_iface_reset_o
);
    logic [7:0] ctrl4_q;
    logic [7:0] ctrl5_q;
    logic [7:0] ctrl5_prev_q;
    logic [1:0] rx_s1_q;
    logic [1:0] rx_s2_q;
    logic [1:0] tx_s1_q;
    logic [1:0] tx_s2_q;
    logic [ELMC_SLOT_BITS-1:0] tx_snoop_q;
    logic [ELMC_SLOT_BITS-1:0] rx_snoop_q;
    logic rx_align_q;
    logic tx_align_q;
    logic [4:0] li_cnt_q;
    logic remote_loop_enable;
    logic local_loop_enable;
    logic line_alarm_ones_force;
    logic [ELMC_SEL_W-1:0] tx_chan_select;
    logic [ELMC_SEL_W-1:0] rx_chan_select;
    logic line_rst_rise;
    logic rx_align_rise;
    logic tx_align_rise;
    logic line_rx_pos_in;
    logic line_rx_neg_in;
    logic line_tx_pos_in;
    logic line_tx_neg_in;

    assign remote_loop_enable = ctrl4_q[ELMC_REMOTE_LOOP_BIT];
    assign local_loop_enable = ctrl4_q[ELMC_LOCAL_LOOP_BIT];
    assign line_alarm_ones_force = ctrl4_q[ELMC_ALARM_ONES_BIT];
    assign tx_chan_select = ctrl4_q[ELMC_SEL_MSB:0];
    assign rx_chan_select = ctrl5_q[ELMC_SEL_MSB:0];

    // Register writes
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl4_q <= ELMC_CTRL4_RST;
            ctrl5_q <= ELMC_CTRL5_RST;
        end else if (wr_i) begin
            if (addr_i == ELMC_CTRL4_ADDR) begin
                ctrl4_q <= wdata_i;
            end
            if (addr_i == ELMC_CTRL5_ADDR) begin
                ctrl5_q <= wdata_i;
            end
        end
    end

    // Read data
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                ELMC_CTRL4_ADDR: rdata_o <= ctrl4_q;
                ELMC_CTRL5_ADDR: rdata_o <= ctrl5_q;
                default: rdata_o <= 8'h00;
            endcase
        end
    end

    // Edge detection of command bits
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl5_prev_q <= ELMC_CTRL5_RST;
        end else begin
            ctrl5_prev_q <= ctrl5_q;
        end
    end

    assign line_rst_rise = ctrl5_q[ELMC_LINE_RESET_BIT] &
        ~ctrl5_prev_q[ELMC_LINE_RESET_BIT];
    assign rx_align_rise = ctrl5_q[ELMC_RX_ALIGN_BIT] &
        ~ctrl5_prev_q[ELMC_RX_ALIGN_BIT];
    assign tx_align_rise = ctrl5_q[ELMC_TX_ALIGN_BIT] &
        ~ctrl5_prev_q[ELMC_TX_ALIGN_BIT];

    // Line interface reset pulse
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            li_cnt_q <= 5'h00;
        end else if (line_rst_rise) begin
            li_cnt_q <= 5'(ELMC_LI_RESET_CYCLES);
        end else if (li_cnt_q != 5'h00) begin
            li_cnt_q <= li_cnt_q - 5'h01;
        end
    end
    assign line_iface_reset_o = (li_cnt_q != 5'h00);

    // Align commands, only when separation below half a frame
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_align_q <= 1'b0;
            tx_align_q <= 1'b0;
        end else begin
            rx_align_q <= rx_align_rise && (rx_elastic_sep_i < ELMC_HALF_FRAME);
            tx_align_q <= tx_align_rise && (tx_elastic_sep_i < ELMC_HALF_FRAME);
        end
    end
    // Executed pulse lets the store jump pointers, data may break
    assign rx_elastic_align_o = rx_align_q;
    assign tx_elastic_align_o = tx_align_q;

    // Receive pair synchroniser
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_s1_q <= 2'h0;
            rx_s2_q <= 2'h0;
        end else begin
            rx_s1_q <= {line_rx_pos_in_i, line_rx_neg_in_i};
            rx_s2_q <= rx_s1_q;
        end
    end

    // Formatter pair synchroniser
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_s1_q <= 2'h0;
            tx_s2_q <= 2'h0;
        end else begin
            tx_s1_q <= {line_tx_pos_in_i, line_tx_neg_in_i};
            tx_s2_q <= tx_s1_q;
        end
    end
    assign line_rx_pos_in = rx_s2_q[1];
    assign line_rx_neg_in = rx_s2_q[0];
    assign line_tx_pos_in = tx_s2_q[1];
    assign line_tx_neg_in = tx_s2_q[0];

    // Line transmit pair, alarm-ones ahead of remote loop
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            line_tx_pos_out_o <= 1'b0;
            line_tx_neg_out_o <= 1'b0;
        end else begin
            if (line_alarm_ones_force) begin
                line_tx_pos_out_o <= ~line_tx_pos_out_o;
                line_tx_neg_out_o <= line_tx_pos_out_o;
            end else if (remote_loop_enable) begin
                line_tx_pos_out_o <= line_rx_pos_in;
                line_tx_neg_out_o <= line_rx_neg_in;
            end else begin
                line_tx_pos_out_o <= line_tx_pos_in;
                line_tx_neg_out_o <= line_tx_neg_in;
            end
        end
    end

    // Receive data toward jitter attenuator
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_pos_to_jitter_o <= 1'b0;
            rx_neg_to_jitter_o <= 1'b0;
        end else begin
            if (local_loop_enable) begin
                rx_pos_to_jitter_o <= line_tx_pos_in;
                rx_neg_to_jitter_o <= line_tx_neg_in;
            end else begin
                rx_pos_to_jitter_o <= line_rx_pos_in;
                rx_neg_to_jitter_o <= line_rx_neg_in;
            end
        end
    end

    // Receive framer feed, unaffected by remote loop
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            framer_pos_o <= 1'b0;
            framer_neg_o <= 1'b0;
        end else begin
            framer_pos_o <= local_loop_enable ? line_tx_pos_in : line_rx_pos_in;
            framer_neg_o <= local_loop_enable ? line_tx_neg_in : line_rx_neg_in;
        end
    end

    // Channel snoop capture
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_snoop_q <= 8'h00;
            rx_snoop_q <= 8'h00;
        end else begin
            if (tx_slot_valid_i && tx_slot_num_i == tx_chan_select) begin
                tx_snoop_q <= tx_slot_data_i;
            end
            if (rx_slot_valid_i && rx_slot_num_i == rx_chan_select) begin
                rx_snoop_q <= rx_slot_data_i;
            end
        end
    end
    assign tx_channel_snoop_o = tx_snoop_q;
    assign rx_channel_snoop_o = rx_snoop_q;
endmodule

// ### elmc_pkg.sv
// Constants for the loopback and channel monitor control block
package elmc_pkg;
    localparam logic [7:0] ELMC_CTRL4_ADDR = 8'hA8;
    localparam logic [7:0] ELMC_CTRL5_ADDR = 8'hAA;
    localparam logic [7:0] ELMC_CTRL4_RST = 8'h00;
    localparam logic [7:0] ELMC_CTRL5_RST = 8'h00;
    localparam int ELMC_REMOTE_LOOP_BIT = 7;
    localparam int ELMC_LOCAL_LOOP_BIT = 6;
    localparam int ELMC_ALARM_ONES_BIT = 5;
    localparam int ELMC_LINE_RESET_BIT = 7;
    localparam int ELMC_RX_ALIGN_BIT = 6;
    localparam int ELMC_TX_ALIGN_BIT = 5;
    localparam int ELMC_SEL_MSB = 4;
    localparam int ELMC_SEL_W = 5;
    localparam int ELMC_SLOTS = 32;
    localparam int ELMC_SLOT_BITS = 8;
    localparam int ELMC_FRAME_BITS = ELMC_SLOTS * ELMC_SLOT_BITS;
    localparam int ELMC_PTR_W = 9;
    localparam logic [ELMC_PTR_W-1:0] ELMC_HALF_FRAME = 9'h080;
    localparam int ELMC_LI_RESET_CYCLES = 16;
endpackage

// ### elmc_host.sv
// Host processor model on the parallel control port
`timescale 1ns/1ps
module elmc_host (
    // Clock
    input wire logic sys_clk_i,
    // Control port
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    initial {addr_o, wr_o, rd_o, wdata_o} = '0;
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        {addr_o, wdata_o, wr_o, rd_o} <= {a, d, w, !w};
        @(negedge sys_clk_i);
        {addr_o, wdata_o, wr_o, rd_o} <= {~a, ~d, 2'b00};
    endtask
endmodule

// ### elmc_ctrl_properties.sv
// Port assertions for the loopback and monitor control bank
`timescale 1ns/1ps
module elmc_ctrl_checker import elmc_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic line_rx_pos_in_i,
    input wire logic line_tx_pos_in_i,
    input wire logic line_tx_pos_out_o,
    input wire logic line_tx_neg_out_o,
    input wire logic framer_pos_o,
    input wire logic rx_elastic_align_o,
    input wire logic tx_elastic_align_o,
    input wire logic line_iface_reset_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [7:0] c4_q;
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
        if (sys_rst_i) c4_q <= 8'h00;
        else if (wr_i && addr_i == ELMC_CTRL4_ADDR) c4_q <= wdata_i;
    sequence remote_held; (c4_q[7] && !c4_q[5]) [*4]; endsequence
    sequence local_held; (c4_q[6] && !c4_q[7]) [*4]; endsequence
    remote_loop_a: assert property (remote_held |-> line_tx_pos_out_o == $past(line_rx_pos_in_i, 3)) else $error("remote loop");
    local_loop_a: assert property (local_held |-> framer_pos_o == $past(line_tx_pos_in_i, 3)) else $error("local loop");
    alarm_ones_a: assert property (c4_q[5] [*3] |-> line_tx_pos_out_o != line_tx_neg_out_o) else $error("alarm ones");
    rx_align_a: assert property ($rose(rx_elastic_align_o) |-> $past(wr_i && addr_i == ELMC_CTRL5_ADDR && wdata_i[6], 2)) else $error("rx align cause");
    tx_align_a: assert property ($rose(tx_elastic_align_o) |-> $past(wr_i && addr_i == ELMC_CTRL5_ADDR && wdata_i[5], 2)) else $error("tx align cause");
    align_pulse_a: assert property (rx_elastic_align_o |=> !rx_elastic_align_o) else $error("align pulse");
    line_reset_a: assert property ($rose(line_iface_reset_o) |-> line_iface_reset_o [*8] ##1 line_iface_reset_o [*8] ##1 !line_iface_reset_o) else $error("reset length");
    unmapped_rd_a: assert property (rd_i && addr_i != ELMC_CTRL4_ADDR && addr_i != ELMC_CTRL5_ADDR |=> rdata_o == 8'h00) else $error("unmapped read");
endmodule

// ### e1_loopback_monitor_control_bench.sv
// Self-checking bench for the loopback and monitor control bank
`timescale 1ns/1ps
module e1_loopback_monitor_control_bench import elmc_pkg::*;;
    logic sys_clk_i, sys_rst_i, wr_i, rd_i, pend, line_rx_pos_in_i, line_rx_neg_in_i;
    logic line_tx_pos_in_i, line_tx_neg_in_i, line_tx_pos_out_o, line_tx_neg_out_o;
    logic rx_pos_to_jitter_o, rx_neg_to_jitter_o, framer_pos_o, framer_neg_o;
    logic tx_slot_valid_i, rx_slot_valid_i, rx_elastic_align_o, tx_elastic_align_o;
    logic line_iface_reset_o;
    logic [7:0] addr_i, wdata_i, rdata_o, tx_slot_data_i, rx_slot_data_i, d, e, rq[$];
    logic [7:0] tx_channel_snoop_o, rx_channel_snoop_o;
    logic [4:0] tx_slot_num_i, rx_slot_num_i;
    logic [8:0] rx_elastic_sep_i, tx_elastic_sep_i;
    logic [3:0] v;
    logic [5:0] lq[$];
    logic [7:0] modes [3] = '{8'h00, 8'h80, 8'h40};
    logic [7:0] sels [3] = '{8'h00, 8'h11, 8'h1F};
    int fails, compares, rxp, txp, rstc;
    elmc_ctrl uut (.*);
    elmc_host host (.sys_clk_i, .addr_o(addr_i), .wr_o(wr_i), .rd_o(rd_i), .wdata_o(wdata_i));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
        rq.push_back(x);
        host.access(1'b0, a, 8'h00);
    endtask
    initial begin
        sys_clk_i = 0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) pend <= rd_i;
    always @(negedge sys_clk_i) if (pend) chk(rdata_o, rq.pop_front());
    always @(posedge sys_clk_i) begin
        rxp += rx_elastic_align_o;
        txp += tx_elastic_align_o;
        rstc += line_iface_reset_o;
        #2;
        if (lq.size() == 3) chk({2'b00, line_tx_pos_out_o, line_tx_neg_out_o, framer_pos_o,
            framer_neg_o, rx_pos_to_jitter_o, rx_neg_to_jitter_o}, {2'b00, lq.pop_front()});
    end
    initial begin
        #1000000;
        fails++;
        conclude();
    end
    initial begin
        void'($urandom(3766));
        {sys_rst_i, line_rx_pos_in_i, line_rx_neg_in_i, line_tx_pos_in_i, line_tx_neg_in_i} = 5'h10;
        {tx_slot_data_i, rx_slot_data_i, tx_slot_num_i, rx_slot_num_i} = '0;
        {tx_slot_valid_i, rx_slot_valid_i, rx_elastic_sep_i, tx_elastic_sep_i} = '0;
        repeat (4) @(negedge sys_clk_i);
        sys_rst_i = 0;
        rd_chk(ELMC_CTRL4_ADDR, ELMC_CTRL4_RST);
        rd_chk(ELMC_CTRL5_ADDR, ELMC_CTRL5_RST);
        d = 8'($urandom);
        host.access(1'b1, ELMC_CTRL4_ADDR, d);
        host.access(1'b1, 8'hA9, ~d);
        rd_chk(ELMC_CTRL4_ADDR, d);
        rd_chk(8'hA9, 8'h00);
        foreach (modes[m]) begin
            host.access(1'b1, ELMC_CTRL4_ADDR, modes[m]);
            repeat (40) begin
                @(negedge sys_clk_i);
                v = 4'($urandom);
                {line_rx_pos_in_i, line_rx_neg_in_i, line_tx_pos_in_i, line_tx_neg_in_i} = v;
                lq.push_back({modes[m][7] ? v[3:2] : v[1:0], {2{modes[m][6] ? v[1:0] : v[3:2]}}});
            end
            @(negedge sys_clk_i);
            lq.delete();
        end
        host.access(1'b1, ELMC_CTRL4_ADDR, 8'hA0);
        repeat (3) @(negedge sys_clk_i);
        chk({7'h00, line_tx_pos_out_o ^ line_tx_neg_out_o}, 8'h01);
        foreach (sels[s]) begin
            host.access(1'b1, ELMC_CTRL4_ADDR, sels[s]);
            host.access(1'b1, ELMC_CTRL5_ADDR, sels[s]);
            for (int k = 0; k < ELMC_SLOTS; k++) begin
                @(negedge sys_clk_i);
                {tx_slot_valid_i, rx_slot_valid_i, tx_slot_num_i, rx_slot_num_i} = {2'b11, 5'(k), 5'(k)};
                tx_slot_data_i = 8'($urandom);
                rx_slot_data_i = 8'($urandom);
                if (k == sels[s]) {d, e} = {tx_slot_data_i, rx_slot_data_i};
            end
            @(negedge sys_clk_i);
            {tx_slot_valid_i, rx_slot_valid_i} = 2'b00;
            repeat (2) @(negedge sys_clk_i);
            chk(tx_channel_snoop_o, d);
            chk(rx_channel_snoop_o, e);
        end
        rx_elastic_sep_i = 9'($urandom % 128);
        tx_elastic_sep_i = ELMC_HALF_FRAME;
        host.access(1'b1, ELMC_CTRL5_ADDR, 8'h60);
        host.access(1'b1, ELMC_CTRL5_ADDR, 8'h60);
        host.access(1'b1, ELMC_CTRL5_ADDR, 8'h00);
        tx_elastic_sep_i = 9'h000;
        host.access(1'b1, ELMC_CTRL5_ADDR, 8'h60);
        repeat (3) @(negedge sys_clk_i);
        chk(8'(rxp), 8'h02);
        chk(8'(txp), 8'h01);
        host.access(1'b1, ELMC_CTRL5_ADDR, 8'h80);
        host.access(1'b1, ELMC_CTRL5_ADDR, 8'h80);
        repeat (20) @(negedge sys_clk_i);
        chk(8'(rstc), 8'h10);
        conclude();
    end
endmodule
bind elmc_ctrl elmc_ctrl_checker chk_i (.*);
